// File: design/abst_top.v
/*
  automatic buffer serial transfer engine: register port, buffer ram,
  byte engine, 3-wire serial output and interrupt logic.
  assumes a cpu on the same clock driving one-cycle strobes, and a
  3-wire peripheral clocked by serial_clock_line.
*/
// Functional notes
// R1: start loads first byte, pointer steps after each byte, next byte loaded.
// R2: single pass ends with done interrupt and active flag cleared.
// R3: repeat pass starts on start with port, auto, repeat, transmit enables set.
// R4: repeat pass wraps pointer to zero, no interrupt, resends from first byte.
// R5: repeat pass never writes received data back to buffer ram.
// R6: serial output changes on each falling serial clock edge.
// R7: every transfer unit is exactly eight bits.
// R8: bit order zero is msb first, one lsb first, both directions.
// R9: stop never breaks a byte; suspension waits for byte end.
// R10: on suspension active flag clears after eighth bit.
// R11: start after suspension resumes with the remaining bytes.
// R12: processor idle freezes mid-byte; leaving idle continues from there.
// R13: software keeps basic mode until active flag reads zero.
// R14: software writes last index as byte count minus one before start.
// R15: up to thirty-two bytes per pass, from lowest address upward.
// R16: single pass starts on start with port, auto, transmit set, repeat clear.
// R17: serial output line is low whenever the active flag is clear.
// R18: idle interval between bytes from interval register, longer on ram clash.
`timescale 1ns/10ps
`default_nettype none
`include "abst_defs.vh"

module abst_top #(
  parameter DEPTH = 32,
  parameter AW = 5,
  parameter SCK_HALF = `ABST_SCK_HALF_CYC
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rstn_i,
  // register port
  input wire [5:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // power state
  input wire cpu_idle_i,
  // serial link
  output reg serial_clock_line_o,
  output reg serial_out_line_o,
  input wire serial_in_line_i,
  // interrupts
  output reg transfer_done_irq_o,
  output reg irq_o
);

  localparam ST_IDLE = 3'h0;
  localparam ST_LOAD = 3'h1;
  localparam ST_SHIFT = 3'h2;
  localparam ST_WBACK = 3'h3;
  localparam ST_GAP = 3'h4;

  //////////////////////////////////////////////////////////////////////
  // registers and state
  reg [5:0] serial_mode_reg;
  reg [AW-1:0] transfer_last_index;
  reg [7:0] byte_interval_setting;
  reg [AW-1:0] transfer_pointer_counter;
  reg [1:0] irq_stat;
  reg [1:0] irq_mask;
  reg transfer_active_flag;
  reg stop_pending;
  reg fresh_pass;
  reg [2:0] state;
  reg [7:0] serial_shift_reg;
  reg [3:0] bit_cnt;
  reg [11:0] gap_cnt;
  reg sin_meta;
  reg sin_sync;
  reg done_ev;
  reg susp_ev;

  wire sck;
  wire sck_fall;
  wire sck_rise;
  wire [7:0] cpu_rdata;
  wire [7:0] eng_rdata;
  wire eng_gnt;

  wire port_en = serial_mode_reg[`ABST_MODE_PORT_EN];
  wire auto_en = serial_mode_reg[`ABST_MODE_AUTO_EN];
  wire repeat_mode = serial_mode_reg[`ABST_MODE_REPEAT];
  wire tx_en = serial_mode_reg[`ABST_MODE_TX_EN];
  wire rx_en = serial_mode_reg[`ABST_MODE_RX_EN];
  wire lsb_first = serial_mode_reg[`ABST_MODE_LSB_FIRST];

  wire ram_sel = reg_addr_i[`ABST_RAM_BASE_BIT];
  wire wr_reg = reg_wr_i & ~ram_sel;
  wire wr_mode = wr_reg & (reg_addr_i == `ABST_OFF_MODE);
  wire wr_trig = wr_reg & (reg_addr_i == `ABST_OFF_TRIG);
  wire start_cmd = wr_trig & reg_wdata_i[`ABST_TRIG_START];
  wire stop_cmd = wr_trig & reg_wdata_i[`ABST_TRIG_STOP];
  wire disable_cmd = wr_mode & ~reg_wdata_i[`ABST_MODE_PORT_EN];
  // R3 repeat and R16 single pass share the enable check, repeat bit picks
  wire start_ok = start_cmd & port_en & auto_en & tx_en & ~transfer_active_flag;
  wire last_byte = (transfer_pointer_counter == transfer_last_index);
  // R5 write-back only in single pass with receive enabled
  wire do_wback = rx_en & ~repeat_mode;
  wire eng_req = (state == ST_LOAD) | (state == ST_WBACK);
  wire out_bit = lsb_first ? serial_shift_reg[0] : serial_shift_reg[7];

  function [7:0] shift_in;
    input [7:0] cur;
    input lsb;
    input din;
    begin
      shift_in = lsb ? {din, cur[7:1]} : {cur[6:0], din};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // submodules
  // R15 thirty-two bytes, pointer from zero
  abst_buffer_ram #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_ram (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .cpu_we_i(reg_wr_i & ram_sel),
    .cpu_re_i(reg_rd_i & ram_sel),
    .cpu_addr_i(reg_addr_i[AW-1:0]),
    .cpu_wdata_i(reg_wdata_i),
    .cpu_rdata_o(cpu_rdata),
    .eng_req_i(eng_req),
    .eng_we_i(state == ST_WBACK),
    .eng_addr_i(transfer_pointer_counter),
    .eng_wdata_i(serial_shift_reg),
    .eng_rdata_o(eng_rdata),
    .eng_gnt_o(eng_gnt)
  );

  // R12 idle holds the divider, so a byte stops mid-way and continues
  abst_clk_gen #(
    .HALF(SCK_HALF)
  ) u_clk (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .run_i(state == ST_SHIFT),
    .hold_i(cpu_idle_i),
    .sck_o(sck),
    .fall_o(sck_fall),
    .rise_o(sck_rise)
  );

  //////////////////////////////////////////////////////////////////////
  // input synchroniser
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      sin_meta <= 1'b0;
      sin_sync <= 1'b0;
    end else begin
      sin_meta <= serial_in_line_i;
      sin_sync <= sin_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // software registers
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      serial_mode_reg <= `ABST_MODE_RESET;
      transfer_last_index <= {AW{1'b0}};
      byte_interval_setting <= 8'h00;
      irq_mask <= `ABST_IRQ_RESET;
      irq_stat <= `ABST_IRQ_RESET;
    end else begin
      if (wr_mode) begin
        serial_mode_reg <= reg_wdata_i[5:0];
      end
      // R14 last index is count minus one, written before start
      if (wr_reg && reg_addr_i == `ABST_OFF_LAST) begin
        transfer_last_index <= reg_wdata_i[AW-1:0];
      end
      if (wr_reg && reg_addr_i == `ABST_OFF_INTV) begin
        byte_interval_setting <= reg_wdata_i;
      end
      if (wr_reg && reg_addr_i == `ABST_OFF_IRQ_MASK) begin
        irq_mask <= reg_wdata_i[1:0];
      end
      // a new event wins over a write-one clear in the same cycle
      irq_stat <= (irq_stat & ~((wr_reg && reg_addr_i == `ABST_OFF_IRQ_STAT) ?
        reg_wdata_i[1:0] : 2'h0)) | {susp_ev, done_ev};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // byte engine
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
      transfer_pointer_counter <= {AW{1'b0}};
      transfer_active_flag <= 1'b0;
      stop_pending <= 1'b0;
      fresh_pass <= 1'b1;
      serial_shift_reg <= 8'h00;
      bit_cnt <= 4'h0;
      gap_cnt <= 12'h000;
      done_ev <= 1'b0;
      susp_ev <= 1'b0;
    end else begin
      done_ev <= 1'b0;
      susp_ev <= 1'b0;
      if (stop_cmd && transfer_active_flag) begin
        stop_pending <= 1'b1;
      end
      if (disable_cmd) begin
        // port off aborts at once, no interrupt
        state <= ST_IDLE;
        transfer_active_flag <= 1'b0;
        stop_pending <= 1'b0;
        transfer_pointer_counter <= {AW{1'b0}};
        fresh_pass <= 1'b1;
      end else begin
        case (state)
          ST_IDLE: begin
            if (start_ok) begin
              transfer_active_flag <= 1'b1;
              stop_pending <= 1'b0;
              state <= ST_LOAD;
              fresh_pass <= 1'b0;
              // R11 resume keeps pointer; a finished pass restarts at zero
              if (fresh_pass) begin
                transfer_pointer_counter <= {AW{1'b0}};
              end
            end
          end
          ST_LOAD: begin
            if (stop_pending) begin
              state <= ST_IDLE;
              transfer_active_flag <= 1'b0;
              stop_pending <= 1'b0;
              susp_ev <= 1'b1;
            end else if (eng_gnt && !cpu_idle_i) begin
              // R1 byte at pointer into the shift register
              serial_shift_reg <= eng_rdata;
              bit_cnt <= 4'h0;
              state <= ST_SHIFT;
            end
          end
          ST_SHIFT: begin
            // R7 eight rising edges make one byte
            if (sck_rise) begin
              // R8 input order follows the bit order select
              serial_shift_reg <= shift_in(serial_shift_reg, lsb_first, sin_sync);
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == `ABST_BITS_PER_BYTE - 4'h1) begin
                state <= do_wback ? ST_WBACK : ST_GAP;
                gap_cnt <= {byte_interval_setting, 4'h0} >> 1;
                if (!do_wback) begin
                  if (last_byte && !repeat_mode) begin
                    // R2 single pass complete
                    state <= ST_IDLE;
                    transfer_active_flag <= 1'b0;
                    fresh_pass <= 1'b1;
                    stop_pending <= 1'b0;
                    done_ev <= 1'b1;
                  end else if (last_byte) begin
                    // R4 wrap to first byte, no interrupt
                    transfer_pointer_counter <= {AW{1'b0}};
                  end else begin
                    // R1 pointer steps after the byte
                    transfer_pointer_counter <= transfer_pointer_counter +
                      {{(AW-1){1'b0}}, 1'b1};
                  end
                end
              end
            end
          end
          ST_WBACK: begin
            if (eng_gnt) begin
              state <= ST_GAP;
              if (last_byte) begin
                state <= ST_IDLE;
                transfer_active_flag <= 1'b0;
                fresh_pass <= 1'b1;
                stop_pending <= 1'b0;
                done_ev <= 1'b1;
              end else begin
                transfer_pointer_counter <= transfer_pointer_counter +
                  {{(AW-1){1'b0}}, 1'b1};
              end
            end
          end
          ST_GAP: begin
            // R9 R10 suspend here after the eighth bit, or in load before the next byte starts
            if (stop_pending) begin
              state <= ST_IDLE;
              transfer_active_flag <= 1'b0;
              stop_pending <= 1'b0;
              susp_ev <= 1'b1;
            end else if (gap_cnt == 12'h000) begin
              // R18 ram clash retries in load and stretches the gap
              state <= ST_LOAD;
            end else if (!cpu_idle_i) begin
              gap_cnt <= gap_cnt - 12'h001;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pins, read data and interrupt outputs
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      serial_clock_line_o <= 1'b1;
      serial_out_line_o <= 1'b0;
      reg_rdata_o <= 8'h00;
      transfer_done_irq_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      serial_clock_line_o <= sck;
      // R17 low whenever inactive
      if (!transfer_active_flag) begin
        serial_out_line_o <= 1'b0;
      // R6 R8 new bit on the falling edge, in selected order
      end else if (sck_fall && state == ST_SHIFT) begin
        serial_out_line_o <= out_bit;
      end
      transfer_done_irq_o <= done_ev;
      irq_o <= |(irq_stat & irq_mask);
      reg_rdata_o <= 8'h00;
      if (reg_rd_i) begin
        if (ram_sel) begin
          reg_rdata_o <= cpu_rdata;
        end else begin
          case (reg_addr_i)
            `ABST_OFF_MODE: reg_rdata_o <= {2'h0, serial_mode_reg};
            `ABST_OFF_STAT: reg_rdata_o <= {6'h00, stop_pending, transfer_active_flag};
            `ABST_OFF_LAST: reg_rdata_o <= {{(8-AW){1'b0}}, transfer_last_index};
            `ABST_OFF_INTV: reg_rdata_o <= byte_interval_setting;
            `ABST_OFF_PTR: reg_rdata_o <= {{(8-AW){1'b0}}, transfer_pointer_counter};
            `ABST_OFF_IRQ_STAT: reg_rdata_o <= {6'h00, irq_stat};
            `ABST_OFF_IRQ_MASK: reg_rdata_o <= {6'h00, irq_mask};
            default: reg_rdata_o <= 8'h00;
          endcase
        end
      end
    end
  end

endmodule

`default_nettype wire

// File: design/abst_defs.vh
/*
  constants of the automatic buffer serial transfer block: register
  offsets, field positions, reset values and timing counts.
  assumes inclusion by bare name from the design files under design/.
*/
`ifndef ABST_DEFS_VH
`define ABST_DEFS_VH

// register offsets (index on the plain register port)
`define ABST_OFF_MODE 6'h00
`define ABST_OFF_TRIG 6'h01
`define ABST_OFF_STAT 6'h02
`define ABST_OFF_LAST 6'h03
`define ABST_OFF_INTV 6'h04
`define ABST_OFF_PTR 6'h05
`define ABST_OFF_IRQ_STAT 6'h06
`define ABST_OFF_IRQ_MASK 6'h07
`define ABST_RAM_BASE_BIT 5

// serial_mode_reg fields
`define ABST_MODE_PORT_EN 0
`define ABST_MODE_AUTO_EN 1
`define ABST_MODE_REPEAT 2
`define ABST_MODE_TX_EN 3
`define ABST_MODE_RX_EN 4
`define ABST_MODE_LSB_FIRST 5
`define ABST_MODE_RESET 6'h00

// serial_trigger_reg fields
`define ABST_TRIG_START 0
`define ABST_TRIG_STOP 1

// irq status and mask fields
`define ABST_IRQ_DONE 0
`define ABST_IRQ_SUSP 1
`define ABST_IRQ_RESET 2'h0

// timing
`define ABST_CLK_NS 8
`define ABST_SCK_PERIOD_NS 64
`define ABST_SCK_HALF_CYC ((`ABST_SCK_PERIOD_NS / `ABST_CLK_NS) / 2)
`define ABST_INTV_UNIT_CYC 8
`define ABST_BITS_PER_BYTE 4'h8

`endif

// File: design/abst_buffer_ram.v
/*
  buffer ram of 32 bytes in flip-flops, with a cpu port and an engine port.
  assumes the cpu port has priority; the engine retries when refused.
*/
`timescale 1ns/10ps
`default_nettype none

module abst_buffer_ram #(
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rstn_i,
  // cpu side
  input wire cpu_we_i,
  input wire cpu_re_i,
  input wire [AW-1:0] cpu_addr_i,
  input wire [7:0] cpu_wdata_i,
  output wire [7:0] cpu_rdata_o,
  // engine side
  input wire eng_req_i,
  input wire eng_we_i,
  input wire [AW-1:0] eng_addr_i,
  input wire [7:0] eng_wdata_i,
  output wire [7:0] eng_rdata_o,
  output wire eng_gnt_o
);

  reg [7:0] mem [0:DEPTH-1];

  // cpu access in the same cycle pushes the engine back a cycle
  assign eng_gnt_o = eng_req_i & ~(cpu_we_i | cpu_re_i);
  assign cpu_rdata_o = mem[cpu_addr_i];
  assign eng_rdata_o = mem[eng_addr_i];

  always @(posedge sys_clk_i) begin
    if (cpu_we_i) begin
      mem[cpu_addr_i] <= cpu_wdata_i;
    end else if (eng_gnt_o && eng_we_i) begin
      mem[eng_addr_i] <= eng_wdata_i;
    end
  end

endmodule

`default_nettype wire

// File: design/abst_clk_gen.v
/*
  serial clock generator: divides the system clock into an idle-high
  serial clock and flags each falling and rising edge it makes.
  assumes run drops right after the eighth rising edge flag.
*/
`timescale 1ns/10ps
`default_nettype none
`include "abst_defs.vh"

module abst_clk_gen #(
  parameter HALF = `ABST_SCK_HALF_CYC
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rstn_i,
  // control
  input wire run_i,
  input wire hold_i,
  // outputs
  output reg sck_o,
  output reg fall_o,
  output reg rise_o
);

  reg [7:0] cnt;

  always @(posedge sys_clk_i) begin
    if (!rstn_i || !run_i) begin
      cnt <= 8'h00;
      sck_o <= 1'b1;
      fall_o <= 1'b0;
      rise_o <= 1'b0;
    end else if (hold_i) begin
      // frozen mid-byte while the processor idles
      fall_o <= 1'b0;
      rise_o <= 1'b0;
    end else if (cnt == HALF[7:0] - 8'h01) begin
      cnt <= 8'h00;
      sck_o <= ~sck_o;
      fall_o <= sck_o;
      rise_o <= ~sck_o;
    end else begin
      cnt <= cnt + 8'h01;
      fall_o <= 1'b0;
      rise_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: test/abst_top_chk.sv
/*
  checker of the serial transfer top: serial clock phases, data timing, irq.
  assumes it is bound to abst_top and sees only that module's ports.
*/
`timescale 1ns/10ps
`default_nettype none
module abst_top_chk #(
  parameter SCK_HALF = 4
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // watched ports
  input wire logic cpu_idle_i,
  input wire logic serial_clock_line_o,
  input wire logic serial_out_line_o,
  input wire logic transfer_done_irq_o,
  input wire logic irq_o
);
  logic [7:0] ph_cnt;
  logic [2:0] rise_cnt;
  logic idl;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////
  // idle stretches a phase, so such phases are skipped
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      ph_cnt <= 8'h00;
      rise_cnt <= 3'h0;
      idl <= 1'b0;
    end else begin
      ph_cnt <= $changed(serial_clock_line_o) ? 8'h01 : ph_cnt + {7'h00, ph_cnt != 8'hff};
      idl <= $changed(serial_clock_line_o) ? cpu_idle_i : (idl | cpu_idle_i);
      if ($rose(serial_clock_line_o)) begin
        rise_cnt <= rise_cnt + 3'h1;
      end
    end
  end
  AST_LOW_PHASE: assert property (
    $rose(serial_clock_line_o) && !idl |-> ph_cnt == SCK_HALF)
    else $error("serial clock low phase has the wrong length");
  AST_HIGH_PHASE: assert property (
    $fell(serial_clock_line_o) && !idl |-> ph_cnt >= SCK_HALF)
    else $error("serial clock high phase too short");
  AST_DATA_ON_FALL: assert property (
    disable iff (!rstn_i || cpu_idle_i)
    $rose(serial_out_line_o) |-> $fell(serial_clock_line_o))
    else $error("serial data rose away from a falling clock edge");
  AST_DONE_BYTE_END: assert property (
    transfer_done_irq_o |-> rise_cnt == 3'h0)
    else $error("done raised after a partial byte");
  AST_IRQ_BYTE_END: assert property (
    $rose(irq_o) |-> rise_cnt == 3'h0)
    else $error("interrupt raised in mid byte");
  AST_DONE_PULSE: assert property (
    transfer_done_irq_o |=> !transfer_done_irq_o)
    else $error("done pulse longer than one cycle");
  AST_OUT_LOW_DONE: assert property (
    transfer_done_irq_o |-> !serial_out_line_o ##1 !serial_out_line_o)
    else $error("serial data not low after completion");
  AST_IDLE_FREEZE: assert property (
    $past(cpu_idle_i, 2) && $past(cpu_idle_i) && cpu_idle_i |-> $stable(serial_clock_line_o))
    else $error("serial clock moved while idle");
endmodule
bind abst_top abst_top_chk #(.SCK_HALF(SCK_HALF)) i_abst_top_chk (
  .sys_clk_i(sys_clk_i),
  .rstn_i(rstn_i),
  .cpu_idle_i(cpu_idle_i),
  .serial_clock_line_o(serial_clock_line_o),
  .serial_out_line_o(serial_out_line_o),
  .transfer_done_irq_o(transfer_done_irq_o),
  .irq_o(irq_o)
);
`default_nettype wire

// File: test/abst_periph_model.sv
/*
  far-side 3-wire peripheral: captures each byte on the rising serial clock.
  assumes the clock idles high and data changes on its falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module abst_periph_model (
  // reset and clock
  input wire logic rstn_i,
  input wire logic sys_clk_i,
  // serial link
  input wire logic sck_i,
  input wire logic sout_i,
  output logic sin_o
);
  logic [7:0] q[$];
  logic [7:0] sh;
  logic [2:0] cnt = 3'h0;
  // fixed reply byte, msb first, so a write-back can be checked
  localparam logic [7:0] REPLY = 8'ha6;
  ////////////////////////////////////////
  // sample at rise, eight bits
  always @(posedge sck_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 3'h0;
    end else begin
      sh = {sh[6:0], sout_i};
      cnt <= cnt + 3'h1;
      if (cnt == 3'h7) begin
        q.push_back(sh);
      end
    end
  end
  // next reply bit follows each rising clock, long before the next sample
  always @(posedge sys_clk_i) begin
    sin_o <= REPLY[3'h7 - cnt];
  end
endmodule
`default_nettype wire

// File: test/test_abst_top.sv
/*
  testbench of the serial transfer top: register tasks and transfer scenarios.
  assumes the far-side model and the bound checker are compiled alongside.
*/
`timescale 1ns/10ps
`default_nettype none
module test_abst_top;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [5:0] reg_addr_i = 6'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic cpu_idle_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic sck, sout, sin, done, irq;
  int miscompares = 0;
  int num_checks = 0;
  int ndone = 0;
  int cyc = 0;
  int k;
  logic [7:0] d [4] = '{8'h5a, 8'hc3, 8'h81, 8'h3c};
  always #4 sys_clk_i = ~sys_clk_i;
  abst_top i_abst_top (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .cpu_idle_i(cpu_idle_i),
    .serial_clock_line_o(sck),
    .serial_out_line_o(sout),
    .serial_in_line_i(sin),
    .transfer_done_irq_o(done),
    .irq_o(irq)
  );
  abst_periph_model i_abst_periph_model (
    .rstn_i(rstn_i),
    .sys_clk_i(sys_clk_i),
    .sck_i(sck),
    .sout_i(sout),
    .sin_o(sin)
  );
  ////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o & m, exp);
  endtask
  // waits a bounded time for the interrupt line
  task automatic wirq;
    k = 0;
    while (irq !== 1'b1 && k < 3000) begin
      @(posedge sys_clk_i);
      k++;
    end
    chk({7'h00, irq}, 8'h01);
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      rev[i] = v[7-i];
    end
  endfunction
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (done === 1'b1) begin
      ndone <= ndone + 1;
    end
    if (cyc == 20000) begin
      miscompares++;
      finish_test;
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    rd(6'h1f, 8'hff, 8'h00);
    wr(6'h07, 8'h03);
    wr(6'h04, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(6'h20 + 6'(i), d[i]);
    end
    // single pass of three bytes, msb first
    wr(6'h03, 8'h02);
    wr(6'h00, 8'h0b);
    wr(6'h01, 8'h01);
    wirq;
    for (int i = 0; i < 3; i++) begin
      chk(i_abst_periph_model.q[i], d[i]);
    end
    chk(8'(i_abst_periph_model.q.size()), 8'h03);
    chk(8'(ndone), 8'h01);
    rd(6'h02, 8'h01, 8'h00);
    rd(6'h06, 8'h03, 8'h01);
    wr(6'h06, 8'h01);
    rd(6'h06, 8'h03, 8'h00);
    chk({7'h00, irq}, 8'h00);
    // one byte, lsb first
    i_abst_periph_model.q.delete();
    wr(6'h03, 8'h00);
    wr(6'h00, 8'h2b);
    wr(6'h01, 8'h01);
    wirq;
    chk(i_abst_periph_model.q[0], rev(d[0]));
    wr(6'h06, 8'h01);
    // repeat mode, stopped by software
    i_abst_periph_model.q.delete();
    wr(6'h03, 8'h01);
    wr(6'h00, 8'h1f);
    wr(6'h01, 8'h01);
    k = 0;
    while (i_abst_periph_model.q.size() < 5 && k < 3000) begin
      @(posedge sys_clk_i);
      k++;
    end
    wr(6'h01, 8'h02);
    wirq;
    for (int i = 0; i < 5; i++) begin
      chk(i_abst_periph_model.q[i], d[i%2]);
    end
    chk(8'(ndone), 8'h02);
    rd(6'h20, 8'hff, d[0]);
    wr(6'h06, 8'h03);
    wr(6'h00, 8'h00);
    // suspend after one byte, resume with an idle spell
    i_abst_periph_model.q.delete();
    wr(6'h03, 8'h03);
    wr(6'h00, 8'h0b);
    wr(6'h01, 8'h01);
    repeat (20) @(posedge sys_clk_i);
    wr(6'h01, 8'h02);
    wirq;
    chk(8'(i_abst_periph_model.q.size()), 8'h01);
    rd(6'h02, 8'h01, 8'h00);
    rd(6'h05, 8'hff, 8'h01);
    wr(6'h06, 8'h03);
    wr(6'h01, 8'h01);
    repeat (30) @(posedge sys_clk_i);
    cpu_idle_i <= 1'b1;
    repeat (40) @(posedge sys_clk_i);
    cpu_idle_i <= 1'b0;
    wirq;
    for (int i = 0; i < 4; i++) begin
      chk(i_abst_periph_model.q[i], d[i]);
    end
    chk(8'(ndone), 8'h03);
    // single pass with receive: reply byte lands in the first ram byte
    wr(6'h06, 8'h03);
    wr(6'h03, 8'h00);
    wr(6'h00, 8'h1b);
    wr(6'h01, 8'h01);
    wirq;
    chk(8'(ndone), 8'h04);
    rd(6'h20, 8'hff, i_abst_periph_model.REPLY);
    finish_test;
  end
endmodule
`default_nettype wire
